/* File: rtl/bfxce_map.svh */
// offsets, field positions, reset values and encodings of the bit-field extract and predicated-execute core
// Function
// - normal mode: width from control bits 17..12, offset from bits 5..0.
// - control word comes from a data or accumulator-middle register, or an immediate.
// - source and destination are each accumulator A or B, one select bit each.
// - both extracts right-align the field, its lowest bit landing at bit 0.
// - signed extract fills bits above the field with the field's top bit.
// - unsigned extract fills bits above the field with zeros.
// - field selection and result use the full 56-bit accumulator.
// - sixteen-bit mode: offset from control bits 13..8, width from bits 21..16.
// - predicated op runs and stores only when condition true; else nothing changes.
// - silent predicated prefix never writes the guarded op's flags.
// - flag-updating prefix writes flags only when the condition is true.
// - prefix word: fixed pattern, 4-bit condition field, guarded opcode below.
`ifndef BFXCE_MAP_SVH
`define BFXCE_MAP_SVH

// ==========================================
// register byte offsets
`define BFXCE_OFS_MODE 8'h00
`define BFXCE_OFS_X0 8'h04
`define BFXCE_OFS_X1 8'h08
`define BFXCE_OFS_Y0 8'h0C
`define BFXCE_OFS_Y1 8'h10
`define BFXCE_OFS_A_LO 8'h14
`define BFXCE_OFS_A_HI 8'h18
`define BFXCE_OFS_B_LO 8'h1C
`define BFXCE_OFS_B_HI 8'h20
`define BFXCE_OFS_CCR 8'h24

// ==========================================
// control word field positions
`define BFXCE_WID_HI 17
`define BFXCE_WID_LO 12
`define BFXCE_OFF_HI 5
`define BFXCE_OFF_LO 0
`define BFXCE_WID16_HI 21
`define BFXCE_WID16_LO 16
`define BFXCE_OFF16_HI 13
`define BFXCE_OFF16_LO 8

// ==========================================
// prefix encoding and sizes
`define BFXCE_PFX_PATTERN 12'h202
`define BFXCE_PFX_HI 23
`define BFXCE_PFX_LO 12
`define BFXCE_CC_HI 11
`define BFXCE_CC_LO 8
`define BFXCE_ACC_BITS 56
`define BFXCE_FULL_WIDTH 6'h38

// ==========================================
// reset values
`define BFXCE_RST_ACC 56'h0
`define BFXCE_RST_DATA 24'h0
`define BFXCE_RST_CCR 8'h00
`define BFXCE_RST_MODE 1'b0

`endif

/* File: rtl/bfxce_pkg.sv */
// types shared by the bit-field extract and predicated-execute core
package bfxce_pkg;

  // ==========================================
  // operations the pipeline can issue
  typedef enum logic [2:0] {
    OP_NOP,
    OP_EXT_S,
    OP_EXT_U,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_OR,
    OP_EOR
  } bfxce_op_t;

  // ==========================================
  // one issued instruction from the decoder
  typedef struct packed {
    logic valid;
    bfxce_op_t op;
    logic useImm;
    logic [2:0] ctrlSel;
    logic [23:0] immCtrl;
    logic srcAcc;
    logic dstAcc;
    logic [1:0] aluSrc;
    logic prefixValid;
    logic predUpdate;
    logic [23:0] prefixWord;
  } bfxce_issue_t;

  // ==========================================
  // condition code register layout, bit 7 down to bit 0
  typedef struct packed {
    logic s;
    logic l;
    logic e;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } bfxce_ccr_t;

endpackage

/* File: rtl/bfxce_core.sv */
// bit-field extract and predicated data ALU execution core with APB register access
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "bfxce_map.svh"

module bfxce_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction issue from the decoder
  input wire bfxce_pkg::bfxce_issue_t issue,
  output logic [3:0] condSel,
  input wire logic condTrue,
  // results toward the pipeline
  output logic resultValid,
  output logic [55:0] resultData,
  output bfxce_pkg::bfxce_ccr_t ccrOut,
  output logic sixteenBitMode
);
  import bfxce_pkg::*;

  // ==========================================
  // state
  logic [55:0] accA_ff;
  logic [55:0] accB_ff;
  logic [23:0] dataX0_ff;
  logic [23:0] dataX1_ff;
  logic [23:0] dataY0_ff;
  logic [23:0] dataY1_ff;
  bfxce_ccr_t ccr_ff;
  logic mode16_ff;
  logic [31:0] rdata_ff;
  logic resValid_ff;
  logic [55:0] resData_ff;

  // ==========================================
  // apb decode; zero wait states, read data latched in the setup cycle
  wire apbSetup = psel && !penable;
  wire apbAccess = psel && penable;
  wire hitMode = (paddr == `BFXCE_OFS_MODE);
  wire hitX0 = (paddr == `BFXCE_OFS_X0);
  wire hitX1 = (paddr == `BFXCE_OFS_X1);
  wire hitY0 = (paddr == `BFXCE_OFS_Y0);
  wire hitY1 = (paddr == `BFXCE_OFS_Y1);
  wire hitALo = (paddr == `BFXCE_OFS_A_LO);
  wire hitAHi = (paddr == `BFXCE_OFS_A_HI);
  wire hitBLo = (paddr == `BFXCE_OFS_B_LO);
  wire hitBHi = (paddr == `BFXCE_OFS_B_HI);
  wire hitCcr = (paddr == `BFXCE_OFS_CCR);
  wire apbHit = hitMode | hitX0 | hitX1 | hitY0 | hitY1 | hitALo | hitAHi | hitBLo | hitBHi | hitCcr;
  wire apbWr = apbAccess && pwrite && apbHit;

  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbHit; // unmapped offsets answer with an error, no effect
  assign prdata = rdata_ff;

  // read mux; narrow registers sit in the low bits, the rest reads zero
  wire [31:0] rdMux =
    hitMode ? {31'h0, mode16_ff} :
    hitX0 ? {8'h0, dataX0_ff} :
    hitX1 ? {8'h0, dataX1_ff} :
    hitY0 ? {8'h0, dataY0_ff} :
    hitY1 ? {8'h0, dataY1_ff} :
    hitALo ? accA_ff[31:0] :
    hitAHi ? {8'h0, accA_ff[55:32]} :
    hitBLo ? accB_ff[31:0] :
    hitBHi ? {8'h0, accB_ff[55:32]} :
    hitCcr ? {24'h0, ccr_ff} : 32'h0;

  // ==========================================
  // prefix decode: pattern in the top bits, condition field, guarded opcode below
  wire pfxMatch = (issue.prefixWord[`BFXCE_PFX_HI:`BFXCE_PFX_LO] == `BFXCE_PFX_PATTERN);
  wire predicated = issue.prefixValid && pfxMatch;
  wire pfxBad = issue.prefixValid && !pfxMatch; // a malformed prefix drops the op
  assign condSel = issue.prefixWord[`BFXCE_CC_HI:`BFXCE_CC_LO];

  // ==========================================
  // control word source: data register, accumulator middle, or immediate
  wire [23:0] ctrlReg =
    (issue.ctrlSel == 3'h0) ? dataX0_ff :
    (issue.ctrlSel == 3'h1) ? dataX1_ff :
    (issue.ctrlSel == 3'h2) ? dataY0_ff :
    (issue.ctrlSel == 3'h3) ? dataY1_ff :
    (issue.ctrlSel == 3'h4) ? accA_ff[47:24] :
    (issue.ctrlSel == 3'h5) ? accB_ff[47:24] : 24'h0;
  wire [23:0] ctrlWord = issue.useImm ? issue.immCtrl : ctrlReg;

  // field position follows the arithmetic mode
  wire [5:0] offNorm = ctrlWord[`BFXCE_OFF_HI:`BFXCE_OFF_LO];
  wire [5:0] widNorm = ctrlWord[`BFXCE_WID_HI:`BFXCE_WID_LO];
  wire [5:0] off16 = ctrlWord[`BFXCE_OFF16_HI:`BFXCE_OFF16_LO];
  wire [5:0] wid16 = ctrlWord[`BFXCE_WID16_HI:`BFXCE_WID16_LO];
  wire [5:0] fldOff = mode16_ff ? off16 : offNorm;
  wire [5:0] fldWid = mode16_ff ? wid16 : widNorm;

  // ==========================================
  // extract datapath over the whole 56-bit source
  wire [55:0] srcVal = issue.srcAcc ? accB_ff : accA_ff;
  wire [55:0] dstVal = issue.dstAcc ? accB_ff : accA_ff;
  wire [55:0] shifted = srcVal >> fldOff;
  wire fullWid = (fldWid >= `BFXCE_FULL_WIDTH);
  wire [55:0] fieldMask = fullWid ? {56{1'b1}} : ~({56{1'b1}} << fldWid);
  wire [55:0] fieldBits = shifted & fieldMask;
  wire [5:0] msbIdx = fldWid - 6'h01;
  // zero width has no top bit; offset+width past 56 is undefined, shifted zeros are taken
  wire signBit = (fldWid == 6'h00) ? 1'b0 : (fullWid ? shifted[55] : shifted[msbIdx]);
  // signed fill bit by bit: inside the field the source bit, above it the field's top bit
  // a zero-width field has no top bit, so the whole word fills with zeros
  wire [55:0] extSigned;
  genvar gb;
  generate
    for (gb = 0; gb < 56; gb++) begin : g_fill
      assign extSigned[gb] = fieldMask[gb] ? shifted[gb] : signBit;
    end
  endgenerate
  wire [55:0] extUnsigned = fieldBits;

  // ==========================================
  // guarded ALU datapath: source register applied at accumulator bits 47..24
  wire [23:0] aluSrcVal =
    (issue.aluSrc == 2'h0) ? dataX0_ff :
    (issue.aluSrc == 2'h1) ? dataX1_ff :
    (issue.aluSrc == 2'h2) ? dataY0_ff : dataY1_ff;
  wire [55:0] addend = {{8{aluSrcVal[23]}}, aluSrcVal, 24'h0};
  wire [56:0] sumWide = {1'b0, dstVal} + {1'b0, addend};
  wire [56:0] difWide = {1'b0, dstVal} - {1'b0, addend};
  wire sumOvf = (dstVal[55] == addend[55]) && (sumWide[55] != dstVal[55]);
  wire difOvf = (dstVal[55] != addend[55]) && (difWide[55] != dstVal[55]);
  wire [23:0] midAnd = dstVal[47:24] & aluSrcVal;
  wire [23:0] midOr = dstVal[47:24] | aluSrcVal;
  wire [23:0] midEor = dstVal[47:24] ^ aluSrcVal;
  wire isLogic = (issue.op == OP_AND) || (issue.op == OP_OR) || (issue.op == OP_EOR);

  // result select
  logic [55:0] aluRes;
  always_comb begin
    case (issue.op)
      OP_EXT_S: aluRes = extSigned;
      OP_EXT_U: aluRes = extUnsigned;
      OP_ADD: aluRes = sumWide[55:0];
      OP_SUB: aluRes = difWide[55:0];
      OP_AND: aluRes = {dstVal[55:48], midAnd, dstVal[23:0]};
      OP_OR: aluRes = {dstVal[55:48], midOr, dstVal[23:0]};
      OP_EOR: aluRes = {dstVal[55:48], midEor, dstVal[23:0]};
      default: aluRes = dstVal;
    endcase
  end

  // ==========================================
  // flags the operation produces; scaling and limit bits are left as they stand
  wire topAllOne = &aluRes[55:47];
  wire topAllZero = ~|aluRes[55:47];
  logic [7:0] newFlags;
  bfxce_ccr_t flagCalc;
  always_comb begin
    flagCalc = ccr_ff;
    flagCalc.e = !(topAllOne || topAllZero);
    flagCalc.u = (aluRes[47] == aluRes[46]);
    flagCalc.n = aluRes[55];
    flagCalc.z = (aluRes == 56'h0);
    case (issue.op)
      OP_EXT_S, OP_EXT_U: begin
        flagCalc.v = 1'b0;
        flagCalc.c = 1'b0;
      end
      OP_ADD: begin
        flagCalc.v = sumOvf;
        flagCalc.c = sumWide[56];
      end
      OP_SUB: begin
        flagCalc.v = difOvf;
        flagCalc.c = difWide[56];
      end
      default: begin
        flagCalc.v = 1'b0;
      end
    endcase
    // logical ops report on the middle word only and keep carry
    if (isLogic) begin
      flagCalc.e = ccr_ff.e;
      flagCalc.u = ccr_ff.u;
      flagCalc.n = aluRes[47];
      flagCalc.z = (aluRes[47:24] == 24'h0);
    end
    newFlags = flagCalc;
  end

  // ==========================================
  // commit: a false predicate leaves accumulators and flags untouched
  wire opReal = issue.valid && (issue.op != OP_NOP) && !pfxBad;
  wire execOk = opReal && (!predicated || condTrue);
  wire wrDst = execOk;
  // silent prefix never writes flags; the updating one only on a true condition
  wire wrFlags = execOk && (!predicated || issue.predUpdate);
  wire wrA = wrDst && !issue.dstAcc;
  wire wrB = wrDst && issue.dstAcc;

  assign resultValid = resValid_ff;
  assign resultData = resData_ff;
  assign ccrOut = ccr_ff;
  assign sixteenBitMode = mode16_ff;

  // ==========================================
  // bus write strobes, one per register
  wire wrALo = apbWr && hitALo;
  wire wrAHi = apbWr && hitAHi;
  wire wrBLo = apbWr && hitBLo;
  wire wrBHi = apbWr && hitBHi;
  wire wrCcrBus = apbWr && hitCcr;
  wire wrModeBus = apbWr && hitMode;
  wire [3:0] wrDataBus = {apbWr && hitY1, apbWr && hitY0, apbWr && hitX1, apbWr && hitX0};

  // ==========================================
  // next values; an executing op wins over a bus write to the same register
  // because the pipeline has no way to stall and retry a lost result
  // the two accumulator halves take bus writes independently
  wire [55:0] accABus = {wrAHi ? pwdata[23:0] : accA_ff[55:32], wrALo ? pwdata : accA_ff[31:0]};
  wire [55:0] accBBus = {wrBHi ? pwdata[23:0] : accB_ff[55:32], wrBLo ? pwdata : accB_ff[31:0]};
  wire [55:0] nxt_accA = wrA ? aluRes : accABus;
  wire [55:0] nxt_accB = wrB ? aluRes : accBBus;
  // flags from an op win; software must not rewrite the flags while ops are issued
  wire [7:0] nxt_ccr = wrFlags ? newFlags : (wrCcrBus ? pwdata[7:0] : ccr_ff);
  // data registers and mode are written by software only
  wire [23:0] nxt_dataX0 = wrDataBus[0] ? pwdata[23:0] : dataX0_ff;
  wire [23:0] nxt_dataX1 = wrDataBus[1] ? pwdata[23:0] : dataX1_ff;
  wire [23:0] nxt_dataY0 = wrDataBus[2] ? pwdata[23:0] : dataY0_ff;
  wire [23:0] nxt_dataY1 = wrDataBus[3] ? pwdata[23:0] : dataY1_ff;
  wire nxt_mode16 = wrModeBus ? pwdata[0] : mode16_ff;
  // read data captured at setup so it stands registered through the access cycle
  wire [31:0] nxt_rdata = apbSetup ? rdMux : rdata_ff;
  // result strobe follows each committed destination write; the data holds between
  wire nxt_resValid = wrDst;
  wire [55:0] nxt_resData = wrDst ? aluRes : resData_ff;

  // ==========================================
  // accumulator A
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accA_ff <= `BFXCE_RST_ACC;
    end else begin
      accA_ff <= nxt_accA;
    end
  end

  // accumulator B
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accB_ff <= `BFXCE_RST_ACC;
    end else begin
      accB_ff <= nxt_accB;
    end
  end

  // condition codes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_ff <= `BFXCE_RST_CCR;
    end else begin
      ccr_ff <= nxt_ccr;
    end
  end

  // ==========================================
  // software-only registers
  // data register X0
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataX0_ff <= `BFXCE_RST_DATA;
    end else begin
      dataX0_ff <= nxt_dataX0;
    end
  end

  // data register X1
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataX1_ff <= `BFXCE_RST_DATA;
    end else begin
      dataX1_ff <= nxt_dataX1;
    end
  end

  // data register Y0
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataY0_ff <= `BFXCE_RST_DATA;
    end else begin
      dataY0_ff <= nxt_dataY0;
    end
  end

  // data register Y1
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataY1_ff <= `BFXCE_RST_DATA;
    end else begin
      dataY1_ff <= nxt_dataY1;
    end
  end

  // sixteen-bit mode bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode16_ff <= `BFXCE_RST_MODE;
    end else begin
      mode16_ff <= nxt_mode16;
    end
  end

  // ==========================================
  // bus read and result registers
  // read data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // result strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resValid_ff <= 1'b0;
    end else begin
      resValid_ff <= nxt_resValid;
    end
  end

  // result data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resData_ff <= `BFXCE_RST_ACC;
    end else begin
      resData_ff <= nxt_resData;
    end
  end

endmodule

/* File: dv/bfxce_asserts.sv */
// port-level checks for the extract and predicated-execute core
`timescale 1ns/1ps
`include "bfxce_map.svh"
module bfxce_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bus side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // issue and results
  input wire bfxce_pkg::bfxce_issue_t issue,
  input wire logic [3:0] condSel,
  input wire logic condTrue,
  input wire logic resultValid,
  input wire logic [55:0] resultData,
  input wire bfxce_pkg::bfxce_ccr_t ccrOut,
  input wire logic sixteenBitMode
);
  import bfxce_pkg::*;
  // ========
  // request decode; a bus write to the flags takes effect when the op writes none, so it is excluded
  wire ccrWr = psel && penable && pwrite && paddr == `BFXCE_OFS_CCR;
  wire pfxOk = issue.prefixWord[23:12] == `BFXCE_PFX_PATTERN;
  wire plainOp = issue.valid && issue.op != OP_NOP && !issue.prefixValid;
  wire guarded = issue.valid && issue.op != OP_NOP && issue.prefixValid && pfxOk;
  wire isExt = issue.op == OP_EXT_S || issue.op == OP_EXT_U;
  wire [5:0] immWid = sixteenBitMode ? issue.immCtrl[21:16] : issue.immCtrl[17:12];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // a guarded op whose condition failed, and the idle answer it must get
  sequence s_skip;
    guarded && !condTrue;
  endsequence
  sequence s_quiet;
    !resultValid && $stable(resultData);
  endsequence
  // ========
  // properties
  chk_cond_route: assert property (condSel == issue.prefixWord[11:8]) else $error("cond select wrong");
  chk_skip_quiet: assert property (s_skip |=> s_quiet) else $error("false cond wrote");
  chk_bad_prefix: assert property (issue.valid && issue.prefixValid && !pfxOk |=> !resultValid)
    else $error("bad prefix ran");
  chk_silent_flags: assert property (guarded && !issue.predUpdate && !ccrWr |=> $stable(ccrOut))
    else $error("silent prefix wrote flags");
  chk_upd_skip: assert property (s_skip ##0 (issue.predUpdate && !ccrWr) |=> $stable(ccrOut))
    else $error("flags changed on false cond");
  chk_upd_take: assert property (guarded && condTrue && issue.predUpdate && issue.op == OP_OR
    |=> !ccrOut.v && ccrOut.n == resultData[47]) else $error("flags not updated");
  chk_ext_flags: assert property (plainOp && isExt
    |=> !ccrOut.v && !ccrOut.c && ccrOut.n == resultData[55]) else $error("extract flags wrong");
  chk_zero_width: assert property (plainOp && issue.op == OP_EXT_U && issue.useImm && immWid == 6'h0
    |=> resultValid && resultData == 56'h0) else $error("zero width not zero");
endmodule
bind bfxce_core bfxce_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .issue(issue), .condSel(condSel), .condTrue(condTrue),
  .resultValid(resultValid), .resultData(resultData), .ccrOut(ccrOut), .sixteenBitMode(sixteenBitMode));

/* File: dv/bfxce_cond_model.sv */
// pipeline-side condition evaluator facing the core
`timescale 1ns/1ps
module bfxce_cond_model (
  // condition request and truth table
  input wire logic [3:0] condSel,
  input wire logic [15:0] condTable,
  // answer
  output logic condTrue
);
  // answered in the same cycle; the table lets the bench make any code true or false
  assign condTrue = condTable[condSel];
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the extract and predicated-execute core
`timescale 1ns/1ps
`include "bfxce_map.svh"
module testbench;
  import bfxce_pkg::*;
  // ========
  // signals
  logic core_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, condTrue, resultValid, sixteenBitMode;
  logic [3:0] condSel;
  logic [55:0] resultData;
  logic [15:0] condTable = 16'h0;
  bfxce_issue_t issue = '0;
  bfxce_ccr_t ccrOut;
  int err_total = 0, comparisons = 0, cycles = 0;
  // ========
  // clock, design and partner
  always #12.5 core_clk = ~core_clk;
  bfxce_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .issue(issue),
    .condSel(condSel), .condTrue(condTrue), .resultValid(resultValid), .resultData(resultData),
    .ccrOut(ccrOut), .sixteenBitMode(sixteenBitMode));
  bfxce_cond_model u_cond (.condSel(condSel), .condTable(condTable), .condTrue(condTrue));
  // ========
  // common tasks
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [55:0] got, input logic [55:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [32:0] rsp);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rsp = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] rsp;
    apb(1'h1, a, d, rsp);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] rsp;
    apb(1'h0, a, 32'h0, rsp);
    check({23'h0, rsp}, {23'h0, exp});
  endtask
  task automatic acc_load(input logic b, input logic [55:0] v);
    wr(b ? `BFXCE_OFS_B_LO : `BFXCE_OFS_A_LO, v[31:0]);
    wr(b ? `BFXCE_OFS_B_HI : `BFXCE_OFS_A_HI, {8'h0, v[55:32]});
  endtask
  // source is always A, destination B, ALU source X0; select 7 means immediate control
  function automatic bfxce_issue_t mk(bfxce_op_t op, logic [23:0] imm, logic [2:0] sel, logic [23:0] pw,
    logic [1:0] pm);
    mk = '0;
    mk.valid = 1'h1;
    mk.op = op;
    mk.useImm = sel == 3'h7;
    mk.ctrlSel = sel;
    mk.immCtrl = imm;
    mk.dstAcc = 1'h1;
    mk.prefixValid = pm != 2'h0;
    mk.predUpdate = pm == 2'h2;
    mk.prefixWord = pw;
  endfunction
  function automatic logic [55:0] fld(logic [55:0] v, int off, int w, logic sgn);
    logic [55:0] m;
    m = (w >= 56) ? '1 : (56'h1 << w) - 56'h1;
    fld = (v >> off) & m;
    if (sgn && w > 0 && fld[w-1]) fld = fld | ~m;
  endfunction
  // issue one op, then look at the one-cycle answer
  task automatic run(input bfxce_issue_t op, input logic go, input logic [55:0] exp);
    @(posedge core_clk);
    issue <= op;
    @(posedge core_clk);
    issue <= '0;
    @(negedge core_clk);
    check({55'h0, resultValid}, {55'h0, go});
    if (go) check(resultData, exp);
  endtask
  // ========
  // scenarios
  task automatic t_extract();
    logic [55:0] v;
    int offs[6];
    int wids[6];
    bfxce_issue_t op;
    v = 56'hC35A960F1E2D4B;
    offs = '{0, 4, 40, 0, 50, 9};
    wids = '{8, 12, 16, 56, 6, 0};
    acc_load(1'h0, v);
    // overflow and carry start set so that the first extract has to clear them
    wr(`BFXCE_OFS_CCR, 32'h03);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        run(mk(s ? OP_EXT_S : OP_EXT_U, {6'h0, 6'(wids[i]), 6'h2A, 6'(offs[i])}, 3'h7, 24'h0, 2'h0), 1'h1,
          fld(v, offs[i], wids[i], s[0]));
        check({54'h0, ccrOut.v, ccrOut.c}, 56'h0);
      end
    end
    // control word from each data register, width 10 and offset equal to the index
    for (int r = 0; r < 4; r++) begin
      wr(8'h04 + 8'(4 * r), 32'h0000A000 + 32'(r));
      run(mk(OP_EXT_S, 24'h0, 3'(r), 24'h0, 2'h0), 1'h1, fld(v, r, 10, 1'h1));
    end
    // source B into destination A, control word taken from the middle of A
    acc_load(1'h1, ~v);
    op = mk(OP_EXT_U, 24'h0, 3'h4, 24'h0, 2'h0);
    op.srcAcc = 1'h1;
    op.dstAcc = 1'h0;
    run(op, 1'h1, fld(~v, v[29:24], v[41:36], 1'h0));
  endtask
  task automatic t_sixteen();
    logic [55:0] v;
    v = 56'h9F00FF3C5AA5E1;
    acc_load(1'h0, v);
    wr(`BFXCE_OFS_MODE, 32'h1);
    @(negedge core_clk);
    check({55'h0, sixteenBitMode}, 56'h1);
    // low bits carry a decoy offset that only the normal layout would read
    run(mk(OP_EXT_U, {2'h0, 6'h0C, 2'h0, 6'h14, 8'h3F}, 3'h7, 24'h0, 2'h0), 1'h1, fld(v, 20, 12, 1'h0));
    run(mk(OP_EXT_S, {2'h0, 6'h0C, 2'h0, 6'h20, 8'h3F}, 3'h7, 24'h0, 2'h0), 1'h1, fld(v, 32, 12, 1'h1));
    wr(`BFXCE_OFS_MODE, 32'h0);
  endtask
  task automatic t_predicate();
    logic [55:0] eb;
    logic [15:0] tbl;
    bfxce_ccr_t ec;
    eb = 56'h12345678ABCDEF;
    tbl = 16'hA6C5;
    acc_load(1'h1, eb);
    wr(`BFXCE_OFS_X0, 32'h00800001);
    wr(`BFXCE_OFS_CCR, 32'h03);
    ec = 8'h03;
    condTable <= tbl;
    // every condition code, odd ones with the flag-updating prefix
    for (int i = 0; i < 16; i++) begin
      if (tbl[i]) eb[47:24] = eb[47:24] | 24'h800001;
      if (tbl[i] && i[0]) ec = {ec[7:4], eb[47], eb[47:24] == 24'h0, 1'h0, ec[0]};
      run(mk(OP_OR, 24'h0, 3'h0, {12'h202, 4'(i), 8'h00}, i[0] ? 2'h2 : 2'h1), tbl[i], eb);
      check({48'h0, ccrOut}, {48'h0, ec});
    end
    // arithmetic and the other logical ops; X0 sits at bits 47..24 and sign-extends into bits 55..48
    eb = eb + {8'hFF, 24'h800001, 24'h0};
    run(mk(OP_ADD, 24'h0, 3'h0, {12'h202, 4'h0, 8'h00}, 2'h1), 1'h1, eb);
    check({48'h0, ccrOut}, {48'h0, ec});
    run(mk(OP_SUB, 24'h0, 3'h0, {12'h202, 4'h1, 8'h00}, 2'h2), 1'h0, eb);
    eb[47:24] = eb[47:24] ^ 24'h800001;
    run(mk(OP_EOR, 24'h0, 3'h0, 24'h0, 2'h0), 1'h1, eb);
    eb[47:24] = eb[47:24] & 24'h800001;
    ec = {ec[7:4], eb[47], eb[47:24] == 24'h0, 1'h0, ec[0]};
    run(mk(OP_AND, 24'h0, 3'h0, 24'h0, 2'h0), 1'h1, eb);
    check({48'h0, ccrOut}, {48'h0, ec});
    run(mk(OP_OR, 24'h0, 3'h0, 24'h203000, 2'h2), 1'h0, eb);
    rd_chk(`BFXCE_OFS_B_LO, {1'h0, eb[31:0]});
    rd_chk(`BFXCE_OFS_B_HI, {9'h0, eb[55:32]});
  endtask
  // ========
  // timeout and main sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    rd_chk(`BFXCE_OFS_MODE, 33'h0);
    rd_chk(8'h40, 33'h100000000);
    t_extract();
    t_sixteen();
    t_predicate();
    complete_run();
  end
endmodule
